// ===== include/sbct_map.vh
// Purpose: register map, field positions and codes of the compare timer
// Assumes: 8-bit internal peripheral bus with 16-bit byte addresses
// Notes:   included by every design file of the timer
`ifndef SBCT_MAP_VH
`define SBCT_MAP_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define SBCT_ADDR_CTRL     16'hffb6
`define SBCT_ADDR_STAT     16'hffb7
`define SBCT_ADDR_CNT_HI   16'hffb8
`define SBCT_ADDR_CNT_LO   16'hffb9
`define SBCT_ADDR_CMP_HI   16'hffba
`define SBCT_ADDR_CMP_LO   16'hffbb

// ----------------------------------------------------------------
// reset values and read answers
// ----------------------------------------------------------------
`define SBCT_CTRL_RST      8'h00
`define SBCT_STAT_RST      8'h00
`define SBCT_CNT_RST       8'h00
`define SBCT_CMP_RST       8'hff
`define SBCT_RD_NONE       8'hff
`define SBCT_RD_IDLE       8'h00
`define SBCT_BYTE_MAX      8'hff
`define SBCT_WORD_MAX      16'hffff

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define SBCT_C_TOLH        7
`define SBCT_C_CKSH_TOP    6
`define SBCT_C_CKSH_LO     4
`define SBCT_C_TOLL        3
`define SBCT_C_CKSL_TOP    2
`define SBCT_C_CKSL_LO     0

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define SBCT_S_HIGH_OVERFLOW_FLAG        7
`define SBCT_S_HIGH_COMPARE_MATCH_FLAG        6
`define SBCT_S_OVIEH       5
`define SBCT_S_HIGH_COUNTER_CLEAR_ON_MATCH       4
`define SBCT_S_OVFL        3
`define SBCT_S_CMFL        2
`define SBCT_S_OVIEL       1
`define SBCT_S_CCLRL       0

// ----------------------------------------------------------------
// clock select codes
// ----------------------------------------------------------------
`define SBCT_CK_DIV32      2'b00
`define SBCT_CK_DIV16      2'b01
`define SBCT_CK_DIV4       2'b10
`define SBCT_CK_WDIV4      2'b11

// ----------------------------------------------------------------
// prescaler
// ----------------------------------------------------------------
`define SBCT_PRE_W         5
`define SBCT_PRE_32        5'h1f
`define SBCT_PRE_16        4'hf
`define SBCT_PRE_4         2'h3
`define SBCT_WDIV_LAST     2'h3

`endif

// ===== src/sbct_half.v
// Purpose: one 8-bit counter half with clear and load
// Assumes: tick is a one-cycle pulse in the mclk domain
// Notes:   load wins over tick and clear
`timescale 1ns/10ps
`include "sbct_map.vh"

module sbct_half (
  mclk,
  rst_n,
  tick,
  clr,
  load,
  load_val,
  cnt,
  carry
);
  input  wire       mclk;
  input  wire       rst_n;
  input  wire       tick;
  input  wire       clr;
  input  wire       load;
  input  wire [7:0] load_val;
  output wire [7:0] cnt;
  output wire       carry;

  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;

  always @* begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = load_val;
    end else if (tick && clr) begin
      cnt_next = `SBCT_CNT_RST;
    end else if (tick) begin
      cnt_next = cnt_reg + 8'h01;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= `SBCT_CNT_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign cnt   = cnt_reg;
  assign carry = tick && !clr && !load && (cnt_reg == `SBCT_BYTE_MAX);

endmodule // sbct_half

// ===== src/sbct_timer.v
// Purpose: sixteen-bit compare timer, splittable into two 8-bit timers
// Assumes: single-cycle bus strobes; pins asynchronous to mclk
// Notes:   read data answers one cycle after the read strobe
`timescale 1ns/10ps
`include "sbct_map.vh"

module sbct_timer (
  mclk,
  rst_n,
  bus_addr,
  bus_wdata,
  bus_wr,
  bus_rd,
  bus_rdata,
  ext_event_pin,
  watch_clk_pin,
  watch_mode,
  module_standby,
  high_timer_irq_enable,
  low_timer_irq_enable,
  high_irq_req,
  low_irq_req,
  high_toggle_output_pin,
  low_toggle_output_pin
);
  input  wire        mclk;
  input  wire        rst_n;
  input  wire [15:0] bus_addr;
  input  wire [7:0]  bus_wdata;
  input  wire        bus_wr;
  input  wire        bus_rd;
  output wire [7:0]  bus_rdata;
  input  wire        ext_event_pin;
  input  wire        watch_clk_pin;
  input  wire        watch_mode;
  input  wire        module_standby;
  input  wire        high_timer_irq_enable;
  input  wire        low_timer_irq_enable;
  output wire        high_irq_req;
  output wire        low_irq_req;
  output wire        high_toggle_output_pin;
  output wire        low_toggle_output_pin;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [7:0]              ctrl_reg;
  reg [7:0]              stat_reg;
  reg [7:0]              stat_next;
  reg [7:0]              cmp_hi_reg;
  reg [7:0]              cmp_lo_reg;
  reg [7:0]              temp_reg;
  reg [7:0]              rdata_reg;
  reg [7:0]              rdata_next;
  reg                    tmo_hi_reg;
  reg                    tmo_lo_reg;
  reg                    irq_hi_reg;
  reg                    irq_lo_reg;
  reg [`SBCT_PRE_W-1:0]  pre_reg;
  reg [1:0]              wdiv_reg;
  reg                    ext_s1_reg;
  reg                    ext_s2_reg;
  reg                    ext_s3_reg;
  reg                    wclk_s1_reg;
  reg                    wclk_s2_reg;
  reg                    wclk_s3_reg;

  wire [7:0]  cnt_hi;
  wire [7:0]  cnt_lo;
  wire        carry_hi;
  wire        carry_lo;
  wire [15:0] cnt_word;
  wire [15:0] cmp_word;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire       split    = ctrl_reg[`SBCT_C_CKSH_TOP];
  wire [2:0] sel_lo   = ctrl_reg[`SBCT_C_CKSL_TOP:`SBCT_C_CKSL_LO];
  wire [1:0] sel_hi   = ctrl_reg[`SBCT_C_CKSH_TOP-1:`SBCT_C_CKSH_LO];
  wire       cclr_hi  = stat_reg[`SBCT_S_HIGH_COUNTER_CLEAR_ON_MATCH];
  wire       cclr_lo  = stat_reg[`SBCT_S_CCLRL];
  wire       running  = !module_standby;

  assign cnt_word = {cnt_hi, cnt_lo};
  assign cmp_word = {cmp_hi_reg, cmp_lo_reg};

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire acc_ok   = running;
  wire wr_ctrl  = bus_wr && acc_ok && (bus_addr == `SBCT_ADDR_CTRL);
  wire wr_stat  = bus_wr && acc_ok && (bus_addr == `SBCT_ADDR_STAT);
  wire wr_cnth  = bus_wr && acc_ok && (bus_addr == `SBCT_ADDR_CNT_HI);
  wire wr_cntl  = bus_wr && acc_ok && (bus_addr == `SBCT_ADDR_CNT_LO);
  wire wr_cmph  = bus_wr && acc_ok && (bus_addr == `SBCT_ADDR_CMP_HI);
  wire wr_cmpl  = bus_wr && acc_ok && (bus_addr == `SBCT_ADDR_CMP_LO);
  wire rd_cnth  = bus_rd && acc_ok && (bus_addr == `SBCT_ADDR_CNT_HI);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_reg  <= 1'b0;
      ext_s2_reg  <= 1'b0;
      ext_s3_reg  <= 1'b0;
      wclk_s1_reg <= 1'b0;
      wclk_s2_reg <= 1'b0;
      wclk_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg  <= ext_event_pin;
      ext_s2_reg  <= ext_s1_reg;
      ext_s3_reg  <= ext_s2_reg;
      wclk_s1_reg <= watch_clk_pin;
      wclk_s2_reg <= wclk_s1_reg;
      wclk_s3_reg <= wclk_s2_reg;
    end
  end

  wire ext_tick  = ext_s2_reg && !ext_s3_reg;
  wire wclk_edge = wclk_s2_reg && !wclk_s3_reg;

  // ----------------------------------------------------------------
  // prescalers
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg  <= {`SBCT_PRE_W{1'b0}};
      wdiv_reg <= 2'b00;
    end else if (running) begin
      pre_reg <= pre_reg + {{(`SBCT_PRE_W-1){1'b0}}, 1'b1};
      if (wclk_edge) begin
        wdiv_reg <= wdiv_reg + 2'b01;
      end
    end
  end

  wire t_div32 = (pre_reg == `SBCT_PRE_32);
  wire t_div16 = (pre_reg[3:0] == `SBCT_PRE_16);
  wire t_div4  = (pre_reg[1:0] == `SBCT_PRE_4);
  wire t_wdiv4 = wclk_edge && (wdiv_reg == `SBCT_WDIV_LAST);

  // ----------------------------------------------------------------
  // clock selection and low-power gating
  // ----------------------------------------------------------------
  reg raw_lo;
  reg raw_hi;
  reg keep_lo;
  reg keep_hi;

  always @* begin
    raw_lo  = 1'b0;
    keep_lo = 1'b0;
    if (!sel_lo[2]) begin
      raw_lo  = ext_tick;
      keep_lo = 1'b1;
    end else begin
      case (sel_lo[1:0])
        `SBCT_CK_DIV32: raw_lo = t_div32;
        `SBCT_CK_DIV16: raw_lo = t_div16;
        `SBCT_CK_DIV4:  raw_lo = t_div4;
        `SBCT_CK_WDIV4: begin
          raw_lo  = t_wdiv4;
          keep_lo = 1'b1;
        end
        default:        raw_lo = 1'b0;
      endcase
    end
  end

  always @* begin
    raw_hi  = 1'b0;
    keep_hi = 1'b0;
    case (sel_hi)
      `SBCT_CK_DIV32: raw_hi = t_div32;
      `SBCT_CK_DIV16: raw_hi = t_div16;
      `SBCT_CK_DIV4:  raw_hi = t_div4;
      `SBCT_CK_WDIV4: begin
        raw_hi  = t_wdiv4;
        keep_hi = 1'b1;
      end
      default:        raw_hi = 1'b0;
    endcase
  end

  // other clocks are lost in watch mode
  wire tick_lo = running && raw_lo && (!watch_mode || keep_lo);
  wire tick_hi8 = running && raw_hi && (!watch_mode || keep_hi);

  // ----------------------------------------------------------------
  // compare and clear
  // ----------------------------------------------------------------
  wire at_cmp16 = (cnt_word == cmp_word);
  wire at_cmph  = (cnt_hi == cmp_hi_reg);
  wire at_cmpl  = (cnt_lo == cmp_lo_reg);
  wire clr16    = !split && cclr_hi && at_cmp16;
  wire clr_hi8  = split && cclr_hi && at_cmph;
  wire clr_lo8  = split && cclr_lo && at_cmpl;

  wire load16   = !split && wr_cntl;
  wire load_hi  = load16 || (split && wr_cnth);
  wire load_lo  = load16 || (split && wr_cntl);
  wire [7:0] ld_hi_val = split ? bus_wdata : temp_reg;

  wire tick_hi  = split ? tick_hi8 : (carry_lo || (tick_lo && clr16));

  sbct_half u_half_hi (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .tick     (tick_hi),
    .clr      (split ? clr_hi8 : clr16),
    .load     (load_hi),
    .load_val (ld_hi_val),
    .cnt      (cnt_hi),
    .carry    (carry_hi)
  );

  sbct_half u_half_lo (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .tick     (tick_lo),
    .clr      (split ? clr_lo8 : clr16),
    .load     (load_lo),
    .load_val (bus_wdata),
    .cnt      (cnt_lo),
    .carry    (carry_lo)
  );

  // events: a match is the tick that brings the count onto the compare value
  wire nx16_eq = ((cnt_word + 16'h0001) == cmp_word);
  wire nxh_eq  = ((cnt_hi + 8'h01) == cmp_hi_reg);
  wire nxl_eq  = ((cnt_lo + 8'h01) == cmp_lo_reg);
  wire match_hi = split ? (tick_hi8 && !clr_hi8 && nxh_eq && !load_hi)
                        : (tick_lo && !clr16 && nx16_eq && !load16);
  wire match_lo = split && tick_lo && !clr_lo8 && nxl_eq && !load_lo;
  wire ovf_hi   = carry_hi;
  wire ovf_lo   = split && carry_lo;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `SBCT_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= bus_wdata;
    end
  end

  // ----------------------------------------------------------------
  // status register: flags cleared by writing zero, event wins
  // ----------------------------------------------------------------
  always @* begin
    stat_next = stat_reg;
    if (wr_stat) begin
      stat_next[`SBCT_S_OVIEH] = bus_wdata[`SBCT_S_OVIEH];
      stat_next[`SBCT_S_HIGH_COUNTER_CLEAR_ON_MATCH] = bus_wdata[`SBCT_S_HIGH_COUNTER_CLEAR_ON_MATCH];
      stat_next[`SBCT_S_OVIEL] = bus_wdata[`SBCT_S_OVIEL];
      stat_next[`SBCT_S_CCLRL] = bus_wdata[`SBCT_S_CCLRL];
      stat_next[`SBCT_S_HIGH_OVERFLOW_FLAG]  = stat_reg[`SBCT_S_HIGH_OVERFLOW_FLAG] & bus_wdata[`SBCT_S_HIGH_OVERFLOW_FLAG];
      stat_next[`SBCT_S_HIGH_COMPARE_MATCH_FLAG]  = stat_reg[`SBCT_S_HIGH_COMPARE_MATCH_FLAG] & bus_wdata[`SBCT_S_HIGH_COMPARE_MATCH_FLAG];
      stat_next[`SBCT_S_OVFL]  = stat_reg[`SBCT_S_OVFL] & bus_wdata[`SBCT_S_OVFL];
      stat_next[`SBCT_S_CMFL]  = stat_reg[`SBCT_S_CMFL] & bus_wdata[`SBCT_S_CMFL];
    end
    if (ovf_hi) begin
      stat_next[`SBCT_S_HIGH_OVERFLOW_FLAG] = 1'b1;
    end
    if (match_hi) begin
      stat_next[`SBCT_S_HIGH_COMPARE_MATCH_FLAG] = 1'b1;
    end
    if (ovf_lo) begin
      stat_next[`SBCT_S_OVFL] = 1'b1;
    end
    if (match_lo) begin
      stat_next[`SBCT_S_CMFL] = 1'b1;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= `SBCT_STAT_RST;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // ----------------------------------------------------------------
  // compare registers and holding latch
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_hi_reg <= `SBCT_CMP_RST;
      cmp_lo_reg <= `SBCT_CMP_RST;
      temp_reg   <= `SBCT_CNT_RST;
    end else begin
      if (!split && (wr_cnth || wr_cmph)) begin
        temp_reg <= bus_wdata;
      end else if (!split && rd_cnth) begin
        temp_reg <= cnt_lo;
      end
      if (wr_cmpl) begin
        cmp_lo_reg <= bus_wdata;
        if (!split) begin
          cmp_hi_reg <= temp_reg;
        end
      end
      if (split && wr_cmph) begin
        cmp_hi_reg <= bus_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always @* begin
    rdata_next = `SBCT_RD_IDLE;
    if (bus_rd && acc_ok) begin
      case (bus_addr)
        `SBCT_ADDR_CTRL:   rdata_next = `SBCT_RD_NONE;
        `SBCT_ADDR_STAT:   rdata_next = stat_reg;
        `SBCT_ADDR_CNT_HI: rdata_next = cnt_hi;
        `SBCT_ADDR_CNT_LO: rdata_next = split ? cnt_lo : temp_reg;
        `SBCT_ADDR_CMP_HI: rdata_next = cmp_hi_reg;
        `SBCT_ADDR_CMP_LO: rdata_next = cmp_lo_reg;
        default:           rdata_next = `SBCT_RD_NONE;
      endcase
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= `SBCT_RD_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // toggle outputs: a control write wins over a simultaneous match
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tmo_hi_reg <= 1'b0;
      tmo_lo_reg <= 1'b0;
    end else if (wr_ctrl) begin
      tmo_hi_reg <= bus_wdata[`SBCT_C_TOLH];
      tmo_lo_reg <= bus_wdata[`SBCT_C_TOLL];
    end else begin
      if (match_hi) begin
        tmo_hi_reg <= !tmo_hi_reg;
      end
      if (match_lo) begin
        tmo_lo_reg <= !tmo_lo_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_hi_reg <= 1'b0;
      irq_lo_reg <= 1'b0;
    end else begin
      irq_hi_reg <= high_timer_irq_enable &&
                    (stat_reg[`SBCT_S_HIGH_COMPARE_MATCH_FLAG] ||
                     (stat_reg[`SBCT_S_HIGH_OVERFLOW_FLAG] && stat_reg[`SBCT_S_OVIEH]));
      irq_lo_reg <= split && low_timer_irq_enable &&
                    (stat_reg[`SBCT_S_CMFL] ||
                     (stat_reg[`SBCT_S_OVFL] && stat_reg[`SBCT_S_OVIEL]));
    end
  end

  assign bus_rdata              = rdata_reg;
  assign high_irq_req           = irq_hi_reg;
  assign low_irq_req            = irq_lo_reg;
  assign high_toggle_output_pin = tmo_hi_reg;
  assign low_toggle_output_pin  = tmo_lo_reg;

endmodule // sbct_timer

// ===== testbench/sbct_pin_src.sv
// Purpose: pin sources at the timer's far side: watch clock and event input
// Assumes: watch clock runs free and much slower than mclk
// Notes:   pulse gives one clean rising event edge, then rests low
`timescale 1ns/10ps
module sbct_pin_src #(
  parameter WCLK_HALF = 47
) (
  watch_clk_pin,
  ext_event_pin
);
  output reg watch_clk_pin;
  output reg ext_event_pin;

  initial begin
    watch_clk_pin = 1'b0;
    ext_event_pin = 1'b0;
    forever #(WCLK_HALF) watch_clk_pin = ~watch_clk_pin;
  end

  task pulse;
    begin
      #3 ext_event_pin = 1'b1;
      #50 ext_event_pin = 1'b0;
      #50;
    end
  endtask
endmodule // sbct_pin_src

// ===== testbench/sbct_timer_props.sv
// Purpose: port-level checks of the compare timer
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every sbct_timer instance
`timescale 1ns/10ps
`include "sbct_map.vh"
module sbct_timer_props (
  input wire        mclk,
  input wire        rst_n,
  input wire [15:0] bus_addr,
  input wire        bus_wr,
  input wire        bus_rd,
  input wire [7:0]  bus_rdata,
  input wire        module_standby,
  input wire        high_timer_irq_enable,
  input wire        low_timer_irq_enable,
  input wire        high_irq_req,
  input wire        low_irq_req,
  input wire        high_toggle_output_pin,
  input wire        low_toggle_output_pin
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire wr_ctrl = bus_wr && (bus_addr == `SBCT_ADDR_CTRL);
  wire rd_live = bus_rd && !module_standby;
  wire unmapped = (bus_addr < `SBCT_ADDR_CTRL) || (bus_addr > `SBCT_ADDR_CMP_LO);

  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == `SBCT_RD_IDLE)
    else $error("read data not idle");
  a_standby_read: assert property ($past(bus_rd) && $past(module_standby)
    |-> bus_rdata == `SBCT_RD_IDLE) else $error("standby read answered");
  a_ctrl_wo: assert property ($past(rd_live) && $past(bus_addr) == `SBCT_ADDR_CTRL
    |-> bus_rdata == `SBCT_RD_NONE) else $error("control read not blank");
  a_unmapped_read: assert property ($past(rd_live) && $past(unmapped)
    |-> bus_rdata == `SBCT_RD_NONE) else $error("unmapped read not blank");
  a_standby_hold: assert property (module_standby && $past(module_standby)
    |-> $stable(high_toggle_output_pin) && $stable(low_toggle_output_pin))
    else $error("output moved in standby");
  a_high_irq_gate: assert property (!$past(high_timer_irq_enable) |-> !high_irq_req)
    else $error("high request without enable");
  a_low_irq_gate: assert property (!$past(low_timer_irq_enable) |-> !low_irq_req)
    else $error("low request without enable");
  a_match_irq: assert property ($changed(high_toggle_output_pin) && !$past(wr_ctrl)
    && high_timer_irq_enable |=> high_irq_req) else $error("match gave no request");
  a_flag_sticky: assert property (high_irq_req && high_timer_irq_enable
    && !$past(bus_wr) |=> high_irq_req) else $error("request dropped without write");

  c_toggle: cover property ($changed(high_toggle_output_pin));
  c_high_irq: cover property ($rose(high_irq_req));
  c_low_irq: cover property ($rose(low_irq_req));
endmodule // sbct_timer_props

bind sbct_timer sbct_timer_props u_props (
  .mclk                  (mclk),
  .rst_n                 (rst_n),
  .bus_addr              (bus_addr),
  .bus_wr                (bus_wr),
  .bus_rd                (bus_rd),
  .bus_rdata             (bus_rdata),
  .module_standby        (module_standby),
  .high_timer_irq_enable (high_timer_irq_enable),
  .low_timer_irq_enable  (low_timer_irq_enable),
  .high_irq_req          (high_irq_req),
  .low_irq_req           (low_irq_req),
  .high_toggle_output_pin(high_toggle_output_pin),
  .low_toggle_output_pin (low_toggle_output_pin)
);

// ===== testbench/sixteen_bit_compare_timer_test.sv
// Purpose: self-checking bench of the compare timer over its byte bus
// Assumes: inputs change 1 ns after the rising edge of mclk
// Notes:   event edges and the watch clock come from sbct_pin_src
`timescale 1ns/10ps
`include "sbct_map.vh"
module sixteen_bit_compare_timer_test;
  reg         mclk, rst_n, bus_wr, bus_rd, watch_mode, module_standby, hi_en, lo_en;
  reg  [15:0] bus_addr, w;
  reg  [7:0]  bus_wdata, h, l;
  wire [7:0]  bus_rdata;
  wire        hi_irq, lo_irq, hi_pin, lo_pin, watch_clk_pin, ext_event_pin;
  integer     n_mismatch, checks, cyc, i;

  sbct_timer dut (.mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ext_event_pin(ext_event_pin),
    .watch_clk_pin(watch_clk_pin), .watch_mode(watch_mode), .module_standby(module_standby),
    .high_timer_irq_enable(hi_en), .low_timer_irq_enable(lo_en), .high_irq_req(hi_irq),
    .low_irq_req(lo_irq), .high_toggle_output_pin(hi_pin), .low_toggle_output_pin(lo_pin));
  sbct_pin_src u_src (.watch_clk_pin(watch_clk_pin), .ext_event_pin(ext_event_pin));

  // ----------------------------------------------------------------
  // bus tasks and compares
  // ----------------------------------------------------------------
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge mclk) #1;
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(posedge mclk) #1;
      bus_wr = 1'b0;
    end
  endtask
  task rd(input [15:0] a, output [7:0] d);
    begin
      @(posedge mclk) #1;
      bus_addr = a;
      bus_rd = 1'b1;
      @(posedge mclk) #1;
      d = bus_rdata;
      bus_rd = 1'b0;
    end
  endtask
  task wr16(input [15:0] a, input [15:0] v);
    begin
      wr(a, v[15:8]);
      wr(a + 16'h1, v[7:0]);
    end
  endtask
  task rd16(input [15:0] a, output [15:0] v);
    reg [7:0] th, tl;
    begin
      rd(a, th);
      rd(a + 16'h1, tl);
      v = {th, tl};
    end
  endtask
  task idle(input integer n);
    begin
      repeat (n) @(posedge mclk);
      #1;
    end
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task chk_rng(input string nm, input [15:0] lo, input [15:0] hi, input [15:0] g);
    begin
      checks = checks + 1;
      if (g >= lo && g <= hi) begin
      end else begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %s expected %h..%h seen %h", nm, lo, hi, g);
      end
    end
  endtask
  task stop_test;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------
  // clock, reset and cycle ceiling
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 10000) begin
      n_mismatch = n_mismatch + 1;
      stop_test;
    end
  end

  initial begin
    {rst_n, bus_wr, bus_rd, watch_mode, module_standby, hi_en, lo_en} = 7'h00;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    n_mismatch = 0;
    checks = 0;
    cyc = 0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    for (i = 0; i < 7; i = i + 1) begin
      rd(`SBCT_ADDR_CTRL - 16'h1 + i, l);
      chk("reset map", (i >= 2 && i <= 4) ? 16'h00 : 16'hff, l);
    end
    wr16(`SBCT_ADDR_CNT_HI, 16'haa55);
    rd(`SBCT_ADDR_CNT_HI, h);
    u_src.pulse;
    idle(5);
    rd(`SBCT_ADDR_CNT_LO, l);
    chk("latched read", 16'haa55, {h, l});
    wr(`SBCT_ADDR_CNT_HI, 8'h12);
    rd16(`SBCT_ADDR_CNT_HI, w);
    chk("lone high write", 16'haa56, w);
    hi_en = 1'b1;
    wr16(`SBCT_ADDR_CNT_HI, 16'h00ff);
    u_src.pulse;
    idle(5);
    rd16(`SBCT_ADDR_CNT_HI, w);
    chk("carry", 16'h0100, w);
    wr16(`SBCT_ADDR_CNT_HI, 16'hffff);
    u_src.pulse;
    idle(5);
    rd16(`SBCT_ADDR_CNT_HI, w);
    chk("wrap", 16'h0000, w);
    rd(`SBCT_ADDR_STAT, l);
    chk("overflow flag", 16'h80, l);
    chk("irq masked", 16'h0, hi_irq);
    wr(`SBCT_ADDR_STAT, 8'ha0);
    idle(2);
    chk("irq enabled", 16'h1, hi_irq);
    rd(`SBCT_ADDR_STAT, l);
    chk("flag kept", 16'ha0, l);
    wr(`SBCT_ADDR_STAT, 8'h10);
    wr16(`SBCT_ADDR_CMP_HI, 16'h0040);
    rd16(`SBCT_ADDR_CMP_HI, w);
    chk("compare word", 16'h0040, w);
    wr16(`SBCT_ADDR_CNT_HI, 16'h0000);
    wr(`SBCT_ADDR_CTRL, 8'h06);
    idle(280);
    chk("toggle", 16'h1, hi_pin);
    chk("match irq", 16'h1, hi_irq);
    rd(`SBCT_ADDR_STAT, l);
    chk("match flag", 16'h50, l);
    rd16(`SBCT_ADDR_CNT_HI, w);
    chk_rng("cleared", 16'h0, 16'hc, w);
    wr(`SBCT_ADDR_CTRL, 8'h06);
    idle(1);
    chk("preset level", 16'h0, hi_pin);
    wr(`SBCT_ADDR_STAT, 8'h00);
    for (i = 0; i < 3; i = i + 1) begin
      wr(`SBCT_ADDR_CTRL, 8'h04 + i);
      wr16(`SBCT_ADDR_CNT_HI, 16'h0000);
      idle(320);
      rd16(`SBCT_ADDR_CNT_HI, w);
      chk_rng("prescale", i == 2 ? 80 : 10 << i, i == 2 ? 81 : (10 << i) + 1, w);
    end
    watch_mode = 1'b1;
    wr(`SBCT_ADDR_CTRL, 8'h06);
    wr16(`SBCT_ADDR_CNT_HI, 16'h0000);
    idle(100);
    rd16(`SBCT_ADDR_CNT_HI, w);
    chk("watch stop", 16'h0, w);
    wr(`SBCT_ADDR_CTRL, 8'h07);
    wr16(`SBCT_ADDR_CNT_HI, 16'h0000);
    idle(320);
    rd16(`SBCT_ADDR_CNT_HI, w);
    chk_rng("watch run", 16'h7, 16'ha, w);
    watch_mode = 1'b0;
    lo_en = 1'b1;
    wr(`SBCT_ADDR_STAT, 8'h02);
    wr(`SBCT_ADDR_CTRL, 8'h48);
    chk("low preset", 16'h1, lo_pin);
    wr(`SBCT_ADDR_CNT_LO, 8'hff);
    u_src.pulse;
    idle(5);
    rd(`SBCT_ADDR_CNT_LO, l);
    chk("split low", 16'h0, l);
    rd(`SBCT_ADDR_STAT, l);
    chk("low overflow", 16'h0a, l);
    chk("low irq", 16'h1, lo_irq);
    module_standby = 1'b1;
    wr(`SBCT_ADDR_STAT, 8'h00);
    rd(`SBCT_ADDR_STAT, l);
    chk("standby read", 16'h0, l);
    module_standby = 1'b0;
    rd(`SBCT_ADDR_STAT, l);
    chk("standby kept", 16'h0a, l);
    wr(`SBCT_ADDR_CMP_LO, 8'h01);
    u_src.pulse;
    idle(5);
    rd(`SBCT_ADDR_STAT, l);
    chk("low match", 16'h0e, l);
    chk("low toggle", 16'h0, lo_pin);
    wr(`SBCT_ADDR_STAT, 8'h0f);
    u_src.pulse;
    idle(5);
    rd(`SBCT_ADDR_CNT_LO, l);
    chk("low clear", 16'h0, l);
    stop_test;
  end
endmodule // sixteen_bit_compare_timer_test
